/* File: design/dac_output_mute_powerdown_ctrl.sv */
// dac routing, soft mute ramp, zero detect and power sequencing with apb
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps

// Functional notes
// - per pair select, swap or mono source
// - mute request ramps level down to zero
// - mute release ramps back to programmed level
// - early release reverses ramp immediately
// - ramp length scales with current code
// - 8192 zero frames set zero flag
// - non-zero data clears zero flag at once
// - registers initialised, active within 1ms
// - writes accepted only after 1ms init
// - stay down until both clocks present
// - powerdown low floats analog outputs
// - clocks may stop during powerdown
// - zero flag low while powered down
// - code FF 0dB, 0.5dB steps, 00 mute
// - ramp rate select 4080/2040/510/255 frames
// - polarity bit inverts zero flag
module dac_output_mute_powerdown_ctrl #(
    parameter int INIT_WAIT = dac_ctrl_pkg::INIT_CYCLES,
    parameter int FRAME_LOSS = dac_ctrl_pkg::FRAME_LOSS_CYCLES
) (
    // system clock and reset
    input wire logic mclk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device pins
    input wire logic chipPowerdownN,
    input wire logic gentleSilenceRequest,
    output logic zeroFlagOut,
    // link side, one sample pair per dac per frame
    input wire logic frameClock,
    input wire logic [dac_ctrl_pkg::NUM_PAIRS-1:0][31:0] sampleLeftIn,
    input wire logic [dac_ctrl_pkg::NUM_PAIRS-1:0][31:0] sampleRightIn,
    // toward the analog converters
    output logic [dac_ctrl_pkg::NUM_PAIRS-1:0][31:0] dacLeftOut,
    output logic [dac_ctrl_pkg::NUM_PAIRS-1:0][31:0] dacRightOut,
    output logic [dac_ctrl_pkg::NUM_CH-1:0][7:0] attLevelOut,
    output logic sampleStrobe,
    output logic analogHiZ
);
    import dac_ctrl_pkg::*;

    // ====================
    // link domain: capture a frame only when the last one was taken
    logic ackToggle_ff; // follows request once words are taken
    logic [1:0] frameRstSync_ff; // reset brought into the frame domain
    logic reqToggle_ff; // flips once per captured frame
    logic [1:0] ackSync_ff; // ack toggle from mclk domain
    logic [NUM_PAIRS-1:0][31:0] holdL_ff;
    logic [NUM_PAIRS-1:0][31:0] holdR_ff;
    wire frameRst = frameRstSync_ff[1];
    wire linkFree = (reqToggle_ff == ackSync_ff[1]);

    // reset synchroniser; frame clock may be stopped, that is fine
    always_ff @(posedge frameClock)
    begin
        frameRstSync_ff <= {frameRstSync_ff[0], rst};
    end

    // handshake keeps held words stable until mclk side acks them
    always_ff @(posedge frameClock)
    begin
        ackSync_ff <= {ackSync_ff[0], ackToggle_ff};
        if (frameRst)
        begin
            reqToggle_ff <= 1'b0;
            holdL_ff <= '0;
            holdR_ff <= '0;
        end
        else if (linkFree)
        begin
            holdL_ff <= sampleLeftIn;
            holdR_ff <= sampleRightIn;
            reqToggle_ff <= ~reqToggle_ff;
        end
    end

    // ====================
    // mclk domain: synchronisers
    logic [2:0] reqSync_ff; // two sync stages plus edge history
    logic [1:0] pdnSync_ff; // powerdown pin
    logic [1:0] muteSync_ff; // mute pin
    wire frameTick = reqSync_ff[2] ^ reqSync_ff[1];
    wire pdnLevel = pdnSync_ff[1];

    // only the second stage of each synchroniser is read by logic, except reqSync_ff whose third stage also feeds the edge detect
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            reqSync_ff <= 3'h0;
            pdnSync_ff <= 2'h0;
            muteSync_ff <= 2'h0;
            ackToggle_ff <= 1'b0;
        end
        else
        begin
            reqSync_ff <= {reqSync_ff[1:0], reqToggle_ff};
            pdnSync_ff <= {pdnSync_ff[0], chipPowerdownN};
            muteSync_ff <= {muteSync_ff[0], gentleSilenceRequest};
            ackToggle_ff <= reqSync_ff[1];
        end
    end

    // ====================
    // frame presence watchdog
    logic [31:0] frameGap_ff; // mclk cycles since the last frame
    logic frameActive_ff;
    wire gapExpired = (frameGap_ff >= 32'(FRAME_LOSS - 1));

    // frames older than the limit count as a stopped clock
    always_ff @(posedge mclk)
    begin
        if (rst || frameTick)
            frameGap_ff <= '0;
        else if (!gapExpired)
            frameGap_ff <= frameGap_ff + 32'h1;
        if (rst)
            frameActive_ff <= 1'b0;
        else if (frameTick)
            frameActive_ff <= 1'b1;
        else if (gapExpired)
            frameActive_ff <= 1'b0;
    end

    // ====================
    // power sequencing
    pwr_state_t state_ff, nxt_state;
    logic [31:0] initCnt_ff; // counts the settle time after release
    wire initDone = (initCnt_ff >= 32'(INIT_WAIT - 1));
    wire running = (state_ff == PWR_RUN);
    wire poweredDown = (state_ff == PWR_DOWN);
    wire writeOpen = running || (state_ff == PWR_WAITCLK);

    // next state; pin low forces down from any state
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            PWR_DOWN:
                if (pdnLevel) nxt_state = PWR_INIT;
            PWR_INIT:
                if (initDone) nxt_state = PWR_WAITCLK;
            PWR_WAITCLK:
                if (frameActive_ff) nxt_state = PWR_RUN;
            PWR_RUN:
                if (!frameActive_ff) nxt_state = PWR_WAITCLK;
            default:
                nxt_state = PWR_DOWN;
        endcase
        if (!pdnLevel)
            nxt_state = PWR_DOWN;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            state_ff <= PWR_DOWN;
        else
            state_ff <= nxt_state;
        if (rst || state_ff != PWR_INIT)
            initCnt_ff <= '0;
        else if (!initDone)
            initCnt_ff <= initCnt_ff + 32'h1;
    end

    // ====================
    // apb register file
    logic [3:0] ctrl_ff; // mute bit, polarity, ramp rate
    logic [15:0] route_ff; // mono, swap, left flip, right flip
    logic [7:0] zsel_ff; // channels watched by zero detect
    logic [NUM_CH-1:0][7:0] att_ff; // programmed attenuation codes
    logic [NUM_CH-1:0][7:0] level_ff; // current ramped codes
    logic zeroAny_ff;
    wire accessPhase = psel && penable;
    wire isAtt = (paddr >= OFS_ATT0) && (paddr <= OFS_ATT7)
        && (paddr[1:0] == 2'b00);
    wire [2:0] attIdx = 3'((paddr - OFS_ATT0) >> 2);
    wire hitCtrl = (paddr == OFS_CTRL);
    wire hitRoute = (paddr == OFS_ROUTE);
    wire hitZsel = (paddr == OFS_ZSEL);
    wire hitStatus = (paddr == OFS_STATUS);
    wire mapped = hitCtrl || hitRoute || hitZsel || hitStatus || isAtt;
    wire wrEn = accessPhase && pwrite && mapped && writeOpen;
    wire [1:0] rateSel = ctrl_ff[CTRL_RATE_LSB +: 2];
    wire muteReq = muteSync_ff[1] || ctrl_ff[CTRL_MUTE_BIT];
    wire [31:0] statusWord = {22'h0, zeroAny_ff, frameActive_ff,
        running, !poweredDown, 6'(state_ff)};

    // zero-wait slave: pready always high, errors flag refused access
    assign pready = 1'b1;
    assign pslverr = accessPhase && (!mapped || (pwrite && !writeOpen));

    // read mux registered from the setup cycle address
    always_ff @(posedge mclk)
    begin
        if (rst)
            prdata <= '0;
        else if (psel && !penable)
        begin
            if (hitCtrl) prdata <= {28'h0, ctrl_ff};
            else if (hitRoute) prdata <= {16'h0, route_ff};
            else if (hitZsel) prdata <= {24'h0, zsel_ff};
            else if (hitStatus) prdata <= statusWord;
            else if (isAtt) prdata <= {16'h0, level_ff[attIdx],
                att_ff[attIdx]};
            else prdata <= '0;
        end
    end

    // pin powerdown returns every setting to its default
    always_ff @(posedge mclk)
    begin
        if (rst || poweredDown)
        begin
            ctrl_ff <= CTRL_RST;
            route_ff <= ROUTE_RST;
            zsel_ff <= ZSEL_RST;
            att_ff <= {NUM_CH{ATT_RST}};
        end
        else if (wrEn)
        begin
            if (hitCtrl) ctrl_ff <= pwdata[3:0];
            if (hitRoute) route_ff <= pwdata[15:0];
            if (hitZsel) zsel_ff <= pwdata[7:0];
            if (isAtt) att_ff[attIdx] <= pwdata[7:0];
        end
    end

    // ====================
    // frames per code step for the selected ramp rate
    function automatic logic [4:0] stepLen(input logic [1:0] sel);
        case (sel)
            2'b00: stepLen = STEP_0;
            2'b01: stepLen = STEP_1;
            2'b10: stepLen = STEP_2;
            default: stepLen = STEP_3;
        endcase
    endfunction : stepLen

    wire [4:0] curStep = stepLen(rateSel);
    logic [NUM_PAIRS-1:0][31:0] sampleL_ff; // last taken input frame
    logic [NUM_PAIRS-1:0][31:0] sampleR_ff;
    wire [NUM_CH-1:0][31:0] chanData = {sampleR_ff, sampleL_ff};
    logic [NUM_CH-1:0] zeroDet;

    // take the held frame on the synchronised request edge
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            sampleL_ff <= '0;
            sampleR_ff <= '0;
            sampleStrobe <= 1'b0;
        end
        else
        begin
            if (frameTick)
            begin
                sampleL_ff <= holdL_ff;
                sampleR_ff <= holdR_ff;
            end
            sampleStrobe <= frameTick && running;
        end
    end

    // ====================
    // per channel ramp and zero detection
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_chan
            logic [4:0] stepCnt_ff; // frames spent on this code
            logic [13:0] zeroCnt_ff; // consecutive zero frames
            wire [7:0] target = muteReq ? ATT_MUTE : att_ff[ch];
            wire atTarget = (level_ff[ch] == target);
            wire stepNow = (stepCnt_ff >= curStep - 5'h1);

            // one code per step, so duration follows code value
            always_ff @(posedge mclk)
            begin
                if (rst || poweredDown)
                begin
                    level_ff[ch] <= ATT_RST;
                    stepCnt_ff <= '0;
                end
                else if (!running)
                begin
                    // no frames: jump straight to the setting
                    level_ff[ch] <= target;
                    stepCnt_ff <= '0;
                end
                else if (frameTick)
                begin
                    if (atTarget)
                        stepCnt_ff <= '0;
                    else if (stepNow)
                    begin
                        stepCnt_ff <= '0;
                        // target flip reverses direction at once
                        if (level_ff[ch] > target)
                            level_ff[ch] <= level_ff[ch] - 8'h1;
                        else
                            level_ff[ch] <= level_ff[ch] + 8'h1;
                    end
                    else
                        stepCnt_ff <= stepCnt_ff + 5'h1;
                end
            end

            // counter saturates at the detect length
            always_ff @(posedge mclk)
            begin
                if (rst || !running)
                    zeroCnt_ff <= '0;
                else if (frameTick)
                begin
                    if (chanData[ch] != 32'h0)
                        zeroCnt_ff <= '0;
                    else if (zeroCnt_ff < 14'(ZERO_FRAMES))
                        zeroCnt_ff <= zeroCnt_ff + 14'h1;
                end
            end

            assign zeroDet[ch] = zsel_ff[ch]
                && (zeroCnt_ff == 14'(ZERO_FRAMES))
                && (chanData[ch] == 32'h0);
        end
    endgenerate

    // ====================
    // routing, phase flip and outputs
    genvar p;
    generate
        for (p = 0; p < NUM_PAIRS; p++)
        begin : g_pair
            wire single = route_ff[ROUTE_SINGLE_LSB + p];
            wire swap = route_ff[ROUTE_SWAP_LSB + p];
            wire [31:0] srcA = swap ? sampleR_ff[p] : sampleL_ff[p];
            wire [31:0] srcB = (single ^ swap) ? sampleL_ff[p]
                : sampleR_ff[p];
            wire [31:0] outL = route_ff[ROUTE_LFLIP_LSB + p]
                ? 32'(-srcA) : srcA;
            wire [31:0] outR = route_ff[ROUTE_RFLIP_LSB + p]
                ? 32'(-srcB) : srcB;

            // silent data whenever the converters are not running
            always_ff @(posedge mclk)
            begin
                if (rst || !running)
                begin
                    dacLeftOut[p] <= '0;
                    dacRightOut[p] <= '0;
                end
                else
                begin
                    dacLeftOut[p] <= outL;
                    dacRightOut[p] <= outR;
                end
            end
        end
    endgenerate

    // flag gated low when down, polarity applied after detection
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            zeroAny_ff <= 1'b0;
            zeroFlagOut <= 1'b0;
            analogHiZ <= 1'b1;
            attLevelOut <= '0;
        end
        else
        begin
            zeroAny_ff <= |zeroDet;
            if (poweredDown)
                zeroFlagOut <= 1'b0;
            else
                zeroFlagOut <= (|zeroDet) ^ ctrl_ff[CTRL_POL_BIT];
            analogHiZ <= !running;
            attLevelOut <= level_ff;
        end
    end
endmodule : dac_output_mute_powerdown_ctrl

/* File: pkg/dac_ctrl_pkg.sv */
// package of register map, reset values and timing for the dac control block
package dac_ctrl_pkg;
    // ====================
    // sizes
    localparam int NUM_PAIRS = 4;
    localparam int NUM_CH = 8;
    localparam int SAMPLE_W = 32;
    // ====================
    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_ROUTE = 12'h004;
    localparam logic [11:0] OFS_ZSEL = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00C;
    localparam logic [11:0] OFS_ATT0 = 12'h010;
    localparam logic [11:0] OFS_ATT7 = 12'h02C;
    // ====================
    // field positions
    localparam int CTRL_MUTE_BIT = 0;
    localparam int CTRL_POL_BIT = 1;
    localparam int CTRL_RATE_LSB = 2;
    localparam int ROUTE_SINGLE_LSB = 0;
    localparam int ROUTE_SWAP_LSB = 4;
    localparam int ROUTE_LFLIP_LSB = 8;
    localparam int ROUTE_RFLIP_LSB = 12;
    // ====================
    // reset values
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [15:0] ROUTE_RST = 16'h0000;
    localparam logic [7:0] ZSEL_RST = 8'hFF;
    localparam logic [7:0] ATT_RST = 8'hFF;
    localparam logic [7:0] ATT_MUTE = 8'h00;
    // ====================
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int INIT_TIME_NS = 1000000;
    localparam int INIT_CYCLES = INIT_TIME_NS / CLK_PERIOD_NS;
    localparam int FRAME_LOSS_CYCLES = 65536;
    localparam int ZERO_FRAMES = 8192;
    localparam int FULL_CODES = 255;
    localparam int RAMP_FRAMES_0 = 4080;
    localparam int RAMP_FRAMES_1 = 2040;
    localparam int RAMP_FRAMES_2 = 510;
    localparam int RAMP_FRAMES_3 = 255;
    localparam logic [4:0] STEP_0 = 5'(RAMP_FRAMES_0 / FULL_CODES);
    localparam logic [4:0] STEP_1 = 5'(RAMP_FRAMES_1 / FULL_CODES);
    localparam logic [4:0] STEP_2 = 5'(RAMP_FRAMES_2 / FULL_CODES);
    localparam logic [4:0] STEP_3 = 5'(RAMP_FRAMES_3 / FULL_CODES);
    // ====================
    // power sequencing states
    typedef enum logic [1:0] {PWR_DOWN, PWR_INIT, PWR_WAITCLK, PWR_RUN}
        pwr_state_t;
endpackage : dac_ctrl_pkg

/* File: tb/dac_ctrl_monitor.sv */
// assertion checker for the dac control block, bound to its top
`timescale 1ns/1ps

module dac_ctrl_monitor #(
    parameter int INIT_WAIT = 20,
    parameter int FRAME_LOSS = 64
) (
    // clock, reset and register bus
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pslverr,
    // pins and converter side
    input wire logic chipPowerdownN,
    input wire logic gentleSilenceRequest,
    input wire logic zeroFlagOut,
    input wire logic [dac_ctrl_pkg::NUM_PAIRS-1:0][31:0] dacLeftOut,
    input wire logic [dac_ctrl_pkg::NUM_PAIRS-1:0][31:0] dacRightOut,
    input wire logic [dac_ctrl_pkg::NUM_CH-1:0][7:0] attLevelOut,
    input wire logic sampleStrobe,
    input wire logic analogHiZ
);
    import dac_ctrl_pkg::*;
    // ====================
    // helper: cycles since the pin went high, saturating
    logic [31:0] upCnt_ff;
    always_ff @(posedge mclk)
    begin
        if (rst || !chipPowerdownN)
            upCnt_ff <= '0;
        else
            upCnt_ff <= upCnt_ff + 32'(~&upCnt_ff);
    end
    // ====================
    // properties; the pin needs up to four cycles to reach the outputs
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence s_downHeld; !chipPowerdownN [*5]; endsequence
    sequence s_muteHeld; gentleSilenceRequest [*5]; endsequence
    // a level move while running on both sides of the edge
    sequence s_runStep;
        !analogHiZ && !$past(analogHiZ) && $changed(attLevelOut[0]);
    endsequence
    property p_hiz_down; s_downHeld |-> analogHiZ; endproperty
    a_hiz_down: assert property (p_hiz_down)
        else $error("outputs not floating while powered down");
    property p_flag_down; s_downHeld |-> !zeroFlagOut; endproperty
    a_flag_down: assert property (p_flag_down)
        else $error("zero flag high while powered down");
    property p_quiet;
        analogHiZ && $past(analogHiZ) |-> !(|dacLeftOut) && !(|dacRightOut);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("converter data while floating");
    property p_one_code;
        s_runStep |-> attLevelOut[0] == $past(attLevelOut[0]) + 8'h01
            || attLevelOut[0] == $past(attLevelOut[0]) - 8'h01;
    endproperty
    a_one_code: assert property (p_one_code)
        else $error("level moved by more than one code");
    property p_per_frame;
        s_runStep |-> sampleStrobe || $past(sampleStrobe);
    endproperty
    a_per_frame: assert property (p_per_frame)
        else $error("level moved without a frame");
    property p_mute_down;
        s_muteHeld ##0 s_runStep |-> attLevelOut[0] < $past(attLevelOut[0]);
    endproperty
    a_mute_down: assert property (p_mute_down)
        else $error("level rose while mute held");
    property p_early_wr;
        s_downHeld ##0 (psel && penable && pwrite) |-> pslverr;
    endproperty
    a_early_wr: assert property (p_early_wr)
        else $error("write not refused while powered down");
    property p_init_hiz;
        chipPowerdownN && upCnt_ff < INIT_WAIT |-> analogHiZ;
    endproperty
    a_init_hiz: assert property (p_init_hiz)
        else $error("running before init window ended");
endmodule : dac_ctrl_monitor

bind dac_output_mute_powerdown_ctrl dac_ctrl_monitor #(
    .INIT_WAIT(INIT_WAIT), .FRAME_LOSS(FRAME_LOSS)
) monitor (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pslverr(pslverr), .chipPowerdownN(chipPowerdownN),
    .gentleSilenceRequest(gentleSilenceRequest), .zeroFlagOut(zeroFlagOut),
    .dacLeftOut(dacLeftOut), .dacRightOut(dacRightOut),
    .attLevelOut(attLevelOut), .sampleStrobe(sampleStrobe),
    .analogHiZ(analogHiZ)
);

/* File: tb/audio_source_model.sv */
// audio source model: frame clock and sample words toward the device
`timescale 1ns/1ps

module audio_source_model (
    // bench control
    input wire logic frameOn,
    input wire logic [dac_ctrl_pkg::NUM_PAIRS-1:0][31:0] leftVal,
    input wire logic [dac_ctrl_pkg::NUM_PAIRS-1:0][31:0] rightVal,
    // link toward the device
    output logic frameClock,
    output logic [dac_ctrl_pkg::NUM_PAIRS-1:0][31:0] sampleLeftIn,
    output logic [dac_ctrl_pkg::NUM_PAIRS-1:0][31:0] sampleRightIn
);
    import dac_ctrl_pkg::*;
    // ====================
    // 12 ns frame clock, parked low while the link is off
    initial
    begin
        frameClock = 1'b0;
        sampleLeftIn = '0;
        sampleRightIn = '0;
        #3.1;
        forever
        begin
            #6;
            if (frameOn)
            begin
                frameClock = ~frameClock;
                // words change on the fall so the rise sees them settled
                if (!frameClock)
                begin
                    sampleLeftIn = leftVal;
                    sampleRightIn = rightVal;
                end
            end
            else
            begin
                // idle: lines show the inverse
                frameClock = 1'b0;
                sampleLeftIn = ~sampleLeftIn;
                sampleRightIn = ~sampleRightIn;
            end
        end
    end
endmodule : audio_source_model

/* File: tb/dac_output_mute_powerdown_ctrl_tb.sv */
// self-checking bench for the dac control block
`timescale 1ns/1ps

module dac_output_mute_powerdown_ctrl_tb;
    import dac_ctrl_pkg::*;
`define CHK(nm, e, g) cmp(nm, 32'(e), 32'(g))
`define WAITC(c, lim) \
    n = 0; \
    while (!(c) && n < (lim)) \
    begin \
        @(posedge mclk); \
        n++; \
    end \
    if (n >= (lim)) \
        wrapUp(1);
    // ====================
    // signals and expectations
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic chipPowerdownN, gentleSilenceRequest, zeroFlagOut;
    logic frameClock, sampleStrobe, analogHiZ, frameOn;
    logic [NUM_PAIRS-1:0][31:0] sampleLeftIn, sampleRightIn, leftVal;
    logic [NUM_PAIRS-1:0][31:0] rightVal, dacLeftOut, dacRightOut;
    logic [NUM_CH-1:0][7:0] attLevelOut;
    int badCount = 0;
    int checked = 0;
    int n, k;
    localparam logic [31:0] LV = 32'h0000_1234, RV = 32'h0000_5678;
    localparam logic [31:0] NL = 32'hFFFF_EDCC, NR = 32'hFFFF_A988;
    localparam int STEPS [4] = '{STEP_0, STEP_1, STEP_2, STEP_3};
    // route word (same nibble per pair) and both outputs of every pair
    typedef struct packed {logic [15:0] rt; logic [31:0] l, r;} row_t;
    row_t rows [8] = '{'{16'h0000, LV, RV}, '{16'h00F0, RV, LV},
        '{16'h000F, LV, LV}, '{16'h00FF, RV, RV}, '{16'h0F00, NL, RV},
        '{16'hF0F0, RV, NL}, '{16'hFF0F, NL, NL}, '{16'h0FFF, NR, RV}};
    // ====================
    // device and far side; short init window keeps the run brief
    dac_output_mute_powerdown_ctrl #(.INIT_WAIT(20), .FRAME_LOSS(64)) dut (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chipPowerdownN(chipPowerdownN),
        .gentleSilenceRequest(gentleSilenceRequest),
        .zeroFlagOut(zeroFlagOut), .frameClock(frameClock),
        .sampleLeftIn(sampleLeftIn), .sampleRightIn(sampleRightIn),
        .dacLeftOut(dacLeftOut), .dacRightOut(dacRightOut),
        .attLevelOut(attLevelOut), .sampleStrobe(sampleStrobe),
        .analogHiZ(analogHiZ));
    audio_source_model src (.frameOn(frameOn), .leftVal(leftVal),
        .rightVal(rightVal), .frameClock(frameClock),
        .sampleLeftIn(sampleLeftIn), .sampleRightIn(sampleRightIn));
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // ====================
    // helpers
    task automatic cmp(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e)
        begin
            badCount++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic wrapUp(input bit hung);
        if (hung)
            badCount++;
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrapUp
    // one bus transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        int t;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        t = 0;
        do
        begin
            @(posedge mclk);
            t++;
        end
        while (pready !== 1'b1 && t < 50);
        if (t >= 50)
            wrapUp(1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // count taken frames until channel 0 reaches a level
    task automatic ramp(input logic [7:0] lv, output int cnt);
        int t;
        cnt = 0;
        t = 0;
        while (attLevelOut[0] !== lv && t < 20000)
        begin
            @(posedge mclk);
            t++;
            if (sampleStrobe === 1'b1)
                cnt++;
        end
        if (t >= 20000)
            wrapUp(1);
    endtask : ramp
    // ====================
    // main sequence
    initial
    begin
        {rst, chipPowerdownN} = 2'b10;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {gentleSilenceRequest, frameOn} = 2'b01;
        leftVal = {NUM_PAIRS{LV}};
        rightVal = {NUM_PAIRS{RV}};
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        frameOn <= 1'b0;
        repeat (200) @(posedge mclk);
        `CHK("float", 1, analogHiZ);
        `CHK("flag", 0, zeroFlagOut);
        apb(1'b1, OFS_CTRL, 32'h0000_000D);
        `CHK("early write", 1, err);
        apb(1'b0, OFS_ATT0, 32'h0);
        `CHK("att reset", ATT_RST, rdat[7:0]);
        chipPowerdownN <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h0000_000D);
        `CHK("init write", 1, err);
        // init over, yet no link clock: still down
        repeat (100) @(posedge mclk);
        `CHK("no clocks", 1, analogHiZ);
        frameOn <= 1'b1;
        `WAITC(analogHiZ === 1'b0, 200)
        foreach (rows[i])
        begin
            apb(1'b1, OFS_ROUTE, {16'h0, rows[i].rt});
            `CHK("route write", 0, err);
            repeat (3)
            begin
                `WAITC(sampleStrobe === 1'b1, 100)
                @(posedge mclk);
            end
            for (int p = 0; p < NUM_PAIRS; p++)
            begin
                `CHK("left", rows[i].l, dacLeftOut[p]);
                `CHK("right", rows[i].r, dacRightOut[p]);
            end
        end
        // mute bit at every rate: two codes down, then back up
        for (int r = 0; r < 4; r++)
        begin
            apb(1'b1, OFS_CTRL, 32'(r * 4 + 1));
            ramp(8'hFD, k);
            `CHK("pace", 1, k >= 2 * STEPS[r] && k <= 2 * STEPS[r] + 2);
            apb(1'b1, OFS_CTRL, 32'(r * 4));
            ramp(8'hFF, k);
        end
        // pin mute from a programmed level, then early release
        apb(1'b1, OFS_ATT0, 32'h0000_0080);
        ramp(8'h80, k);
        gentleSilenceRequest <= 1'b1;
        ramp(8'h00, k);
        `CHK("mute frames", 1, k >= 128 && k <= 130);
        gentleSilenceRequest <= 1'b0;
        ramp(8'h80, k);
        `CHK("return frames", 1, k >= 128 && k <= 130);
        gentleSilenceRequest <= 1'b1;
        ramp(8'h40, k);
        gentleSilenceRequest <= 1'b0;
        ramp(8'h80, k);
        `CHK("turn back", 1, k >= 64 && k <= 66);
        // zero run on every channel, zero detect watching channel 0 only
        apb(1'b1, OFS_ZSEL, 32'h0000_0001);
        leftVal <= '0;
        rightVal <= '0;
        k = 0;
        n = 0;
        while (zeroFlagOut !== 1'b1 && n < 90000)
        begin
            @(posedge mclk);
            n++;
            if (sampleStrobe === 1'b1)
                k++;
        end
        `CHK("zero frames", 1, k >= ZERO_FRAMES - 1 && k <= ZERO_FRAMES + 3);
        apb(1'b1, OFS_CTRL, 32'h0000_000E);
        repeat (2) @(posedge mclk);
        `CHK("flipped", 0, zeroFlagOut);
        leftVal[0] <= LV;
        `WAITC(zeroFlagOut === 1'b1, 40)
        // powerdown mid-run with the link stopped
        chipPowerdownN <= 1'b0;
        frameOn <= 1'b0;
        repeat (6) @(posedge mclk);
        `CHK("down float", 1, analogHiZ);
        `CHK("down flag", 0, zeroFlagOut);
        chipPowerdownN <= 1'b1;
        repeat (100) @(posedge mclk);
        apb(1'b0, OFS_ATT0, 32'h0);
        `CHK("att default", ATT_RST, rdat[7:0]);
        wrapUp(0);
    end
endmodule : dac_output_mute_powerdown_ctrl_tb
